// File: smb_slave.sv
`timescale 1ns/1ps
// Summary of operation
// - acts as read-write slave for read/write byte and word commands.
// - second byte of a read word comes from the next register.
// - a line low longer than 25ms resets the interface, releases data.
// - unsupported command codes are not acknowledged; data line left high.
// - supported command codes sit in the vendor-specific command range.
// - bus idle when both lines high; no driving low while idle.
// - acknowledged command byte loads its low three bits into the pointer.
// - write word stores first data byte, acknowledges and drops the second.
module smb_slave #(
  parameter int unsigned TIMEOUT_CYC = smb_pkg::TIMEOUT_CYC
) (
  // clock and reset
  input  wire logic                        i_clk,
  input  wire logic                        i_arst_n,
  // bus pins
  input  wire logic                        i_scl,
  input  wire logic                        i_sda_in,
  output logic                             o_serial_data_output_pin,
  output logic                             o_serial_data_output_pin_oe,
  // device address
  input  wire logic [6:0]                  i_slave_addr,
  // register file side
  output logic [smb_pkg::PTR_W-1:0]        o_rd_addr,
  input  wire logic [7:0]                  i_rd_data,
  output logic                             o_wr_en,
  output logic [smb_pkg::PTR_W-1:0]        o_wr_addr,
  output logic [7:0]                       o_wr_data
);

  smb_pkg::smb_line_ev_t          ev;
  smb_pkg::smb_state_t            st_q, st_d;
  logic [7:0]                     sh_q, sh_d;
  logic [7:0]                     cmd_q, cmd_d;
  logic [2:0]                     cnt_q, cnt_d;
  logic                           done_q, done_d;
  logic                           rw_q, rw_d;
  logic                           mack_q, mack_d;
  logic                           wcnt_q, wcnt_d;
  logic                           oe_q, oe_d;
  logic                           wr_q, wr_d;
  logic [7:0]                     wdat_q, wdat_d;
  logic [smb_pkg::PTR_W-1:0]      ptr_q, ptr_d;
  logic [smb_pkg::PTR_W-1:0]      rda_q, rda_d;
  logic                           cmd_ok;

  // ============================================================
  // line monitor
  smb_line_mon #(
    .TIMEOUT_CYC (TIMEOUT_CYC)
  ) u_mon (
    .i_clk    (i_clk),
    .i_arst_n (i_arst_n),
    .i_scl    (i_scl),
    .i_sda    (i_sda_in),
    .o_ev     (ev)
  );

  // vendor-specific block only
  assign cmd_ok = (sh_q[7:smb_pkg::CMD_HI_LSB] == smb_pkg::CMD_BASE[7:smb_pkg::CMD_HI_LSB]);

  // ============================================================
  // transaction state machine
  always_comb begin
    st_d   = st_q;
    sh_d   = sh_q;
    cmd_d  = cmd_q;
    cnt_d  = cnt_q;
    done_d = done_q;
    rw_d   = rw_q;
    mack_d = mack_q;
    wcnt_d = wcnt_q;
    oe_d   = oe_q;
    wr_d   = 1'b0;
    wdat_d = wdat_q;
    ptr_d  = ptr_q;
    rda_d  = rda_q;
    if (ev.timeout || ev.stop) begin
      st_d = smb_pkg::ST_IDLE;                       // stuck bus or stop
      oe_d = 1'b0;                                   // release data line
    end else if (ev.start) begin
      st_d   = smb_pkg::ST_ADDR;                     // start, take the address
      oe_d   = 1'b0;
      cnt_d  = 3'h0;
      done_d = 1'b0;
    end else begin
      // shift in on every rising clock while receiving
      if (ev.rise && (st_q == smb_pkg::ST_ADDR || st_q == smb_pkg::ST_CMD ||
                      st_q == smb_pkg::ST_WDATA || st_q == smb_pkg::ST_RDATA)) begin
        if (st_q != smb_pkg::ST_RDATA) begin
          sh_d = {sh_q[6:0], ev.sda};
        end
        cnt_d  = cnt_q + 3'h1;
        done_d = (cnt_q == 3'h7);
      end
      unique case (st_q)
        smb_pkg::ST_IDLE, smb_pkg::ST_IGNORE: begin
          oe_d = 1'b0;                               // never drive while idle
        end
        smb_pkg::ST_ADDR: begin
          if (ev.fall && done_q) begin
            done_d = 1'b0;
            if (sh_q[7:1] == i_slave_addr) begin
              st_d = smb_pkg::ST_ADDR_ACK;           // address ack
              rw_d = sh_q[0];
              oe_d = 1'b1;
            end else begin
              st_d = smb_pkg::ST_IGNORE;
            end
          end
        end
        smb_pkg::ST_ADDR_ACK: begin
          if (ev.fall) begin
            cnt_d = 3'h0;
            if (rw_q) begin
              st_d = smb_pkg::ST_RDATA;              // read from the pointed register
              sh_d = i_rd_data;
              oe_d = ~i_rd_data[7];
            end else begin
              st_d = smb_pkg::ST_CMD;
              oe_d = 1'b0;
            end
          end
        end
        smb_pkg::ST_CMD: begin
          if (ev.fall && done_q) begin
            done_d = 1'b0;
            cmd_d  = sh_q;
            if (cmd_ok) begin
              st_d  = smb_pkg::ST_CMD_ACK;
              oe_d  = 1'b1;
              ptr_d = sh_q[smb_pkg::PTR_W-1:0];      // low three bits only
              rda_d = sh_q[smb_pkg::PTR_W-1:0];
            end else begin
              st_d = smb_pkg::ST_IGNORE;             // no ack, line stays high
            end
          end
        end
        smb_pkg::ST_CMD_ACK: begin
          if (ev.fall) begin
            st_d   = smb_pkg::ST_WDATA;
            oe_d   = 1'b0;
            cnt_d  = 3'h0;
            wcnt_d = 1'b0;
          end
        end
        smb_pkg::ST_WDATA: begin
          if (ev.fall && done_q) begin
            done_d = 1'b0;
            st_d   = smb_pkg::ST_WDATA_ACK;
            oe_d   = 1'b1;                           // ack every data byte
            if (!wcnt_q) begin
              wr_d   = 1'b1;                         // only the first byte is stored
              wdat_d = sh_q;
            end
            wcnt_d = 1'b1;
          end
        end
        smb_pkg::ST_WDATA_ACK: begin
          if (ev.fall) begin
            st_d  = smb_pkg::ST_WDATA;
            oe_d  = 1'b0;
            cnt_d = 3'h0;
          end
        end
        smb_pkg::ST_RDATA: begin
          if (ev.fall) begin
            if (done_q) begin
              done_d = 1'b0;
              st_d   = smb_pkg::ST_RACK;
              oe_d   = 1'b0;
              mack_d = 1'b0;
            end else begin
              sh_d = {sh_q[6:0], 1'b0};
              oe_d = ~sh_q[6];
            end
          end
        end
        smb_pkg::ST_RACK: begin
          if (ev.rise && !ev.sda) begin
            mack_d = 1'b1;
            rda_d  = ptr_q + 3'h1;                   // next register for second byte
          end
          if (ev.fall) begin
            if (mack_q) begin
              st_d  = smb_pkg::ST_RDATA;
              sh_d  = i_rd_data;
              oe_d  = ~i_rd_data[7];
              cnt_d = 3'h0;
            end else begin
              st_d = smb_pkg::ST_IGNORE;
            end
          end
        end
        default: begin
          st_d = smb_pkg::ST_IDLE;
          oe_d = 1'b0;
        end
      endcase
    end
  end

  // ============================================================
  // state registers
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      st_q   <= smb_pkg::ST_IDLE;
      sh_q   <= smb_pkg::SHIFT_RST;
      cmd_q  <= smb_pkg::SHIFT_RST;
      cnt_q  <= 3'h0;
      done_q <= 1'b0;
      rw_q   <= 1'b0;
      mack_q <= 1'b0;
      wcnt_q <= 1'b0;
      oe_q   <= 1'b0;
      wr_q   <= 1'b0;
      wdat_q <= smb_pkg::SHIFT_RST;
      ptr_q  <= smb_pkg::PTR_RST;
      rda_q  <= smb_pkg::PTR_RST;
    end else begin
      st_q   <= st_d;
      sh_q   <= sh_d;
      cmd_q  <= cmd_d;
      cnt_q  <= cnt_d;
      done_q <= done_d;
      rw_q   <= rw_d;
      mack_q <= mack_d;
      wcnt_q <= wcnt_d;
      oe_q   <= oe_d;
      wr_q   <= wr_d;
      wdat_q <= wdat_d;
      ptr_q  <= ptr_d;
      rda_q  <= rda_d;
    end
  end

  // ============================================================
  // outputs
  assign o_serial_data_output_pin    = 1'b0;         // open drain, only pulls low
  assign o_serial_data_output_pin_oe = oe_q;
  assign o_rd_addr                   = rda_q;
  assign o_wr_en                     = wr_q;
  assign o_wr_addr                   = ptr_q;
  assign o_wr_data                   = wdat_q;

  // ============================================================
  // checks
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);

  a_idle_release: assert property (
    st_q == smb_pkg::ST_IDLE |-> !o_serial_data_output_pin_oe)
    else $error("data line driven while idle");
  a_timeout_reset: assert property (
    ev.timeout |=> st_q == smb_pkg::ST_IDLE ##1 !o_serial_data_output_pin_oe)
    else $error("timeout did not reset interface");
  a_bad_cmd_nack: assert property (
    st_q == smb_pkg::ST_CMD && ev.fall && done_q && !cmd_ok && !ev.start && !ev.stop && !ev.timeout
    |=> !o_serial_data_output_pin_oe [*2])
    else $error("unsupported command acknowledged");
  a_cmd_range: assert property (
    o_wr_en |-> cmd_q[7:3] == smb_pkg::CMD_BASE[7:3])
    else $error("write with out-of-range command");
  a_ptr_load: assert property (
    st_q == smb_pkg::ST_CMD_ACK |-> ptr_q == cmd_q[2:0] && o_serial_data_output_pin_oe)
    else $error("pointer not loaded from command");
  a_word_discard: assert property (
    o_wr_en |=> wcnt_q && !o_wr_en)
    else $error("second write byte not discarded");
  a_second_byte: assert property (
    st_q == smb_pkg::ST_RACK && ev.rise && !ev.sda && !ev.start && !ev.stop && !ev.timeout
    |=> o_rd_addr == ptr_q + 3'h1)
    else $error("read word second byte address wrong");
  a_addr_ack: assert property (
    $rose(st_q == smb_pkg::ST_ADDR_ACK) |-> $past(sh_q[7:1]) == i_slave_addr && o_serial_data_output_pin_oe)
    else $error("address ack without match");

endmodule

// File: smb_pkg.sv
// ============================================================
// shared constants and types of the serial slave interface
package smb_pkg;

  // ============================================================
  // timing
  localparam int unsigned CLK_HZ      = 40_000_000;               // core clock rate
  localparam int unsigned TIMEOUT_MS  = 25;                       // stuck-line timeout
  localparam int unsigned TIMEOUT_CYC = (CLK_HZ / 1000) * TIMEOUT_MS;
  localparam int unsigned TMR_W       = 20;                       // timeout counter width

  // ============================================================
  // command decode
  localparam logic [7:0] CMD_BASE    = 8'hD0;                     // vendor-specific command block
  localparam int unsigned PTR_W      = 3;                         // register pointer width
  localparam int unsigned CMD_HI_LSB = 3;                         // first bit above the pointer

  // ============================================================
  // reset values
  localparam logic [7:0]       SHIFT_RST = 8'h00;
  localparam logic [PTR_W-1:0] PTR_RST   = 3'h0;

  // ============================================================
  // bus line events, one clock per event
  typedef struct packed {
    logic start;     // start or repeated start
    logic stop;      // stop condition
    logic rise;      // clock line rose
    logic fall;      // clock line fell
    logic sda;       // synchronised data level
    logic timeout;   // a line stuck low too long
  } smb_line_ev_t;

  // ============================================================
  // transaction states
  typedef enum logic [3:0] {
    ST_IDLE      = 4'h0,
    ST_ADDR      = 4'h1,
    ST_ADDR_ACK  = 4'h3,
    ST_CMD       = 4'h2,
    ST_CMD_ACK   = 4'h6,
    ST_WDATA     = 4'h7,
    ST_WDATA_ACK = 4'h5,
    ST_RDATA     = 4'h4,
    ST_RACK      = 4'hC,
    ST_IGNORE    = 4'h8
  } smb_state_t;

endpackage

// File: smb_line_mon.sv
`timescale 1ns/1ps
// ============================================================
// line synchroniser, start/stop detector, stuck-low timer
module smb_line_mon #(
  parameter int unsigned TIMEOUT_CYC = smb_pkg::TIMEOUT_CYC
) (
  // clock and reset
  input  wire logic                 i_clk,
  input  wire logic                 i_arst_n,
  // bus pins
  input  wire logic                 i_scl,
  input  wire logic                 i_sda,
  // events
  output smb_pkg::smb_line_ev_t     o_ev
);

  logic [1:0]               sync1_q, sync2_q, prev_q;  // bit1 scl, bit0 sda
  logic [smb_pkg::TMR_W-1:0] tmr_q, tmr_d;
  logic                     tmo_q, tmo_d;
  smb_pkg::smb_line_ev_t    ev_d, ev_q;

  // ============================================================
  // two-stage synchroniser and history
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      sync1_q <= 2'h3;
      sync2_q <= 2'h3;
      prev_q  <= 2'h3;
      tmr_q   <= '0;
      tmo_q   <= 1'b0;
      ev_q    <= '0;
    end else begin
      sync1_q <= {i_scl, i_sda};
      sync2_q <= sync1_q;
      prev_q  <= sync2_q;
      tmr_q   <= tmr_d;
      tmo_q   <= tmo_d;
      ev_q    <= ev_d;
    end
  end

  // ============================================================
  // event decode and timer
  always_comb begin
    ev_d       = '0;
    ev_d.sda   = sync2_q[0];
    ev_d.rise  = sync2_q[1] & ~prev_q[1];
    ev_d.fall  = ~sync2_q[1] & prev_q[1];
    ev_d.start = sync2_q[1] & prev_q[1] & prev_q[0] & ~sync2_q[0];
    ev_d.stop  = sync2_q[1] & prev_q[1] & ~prev_q[0] & sync2_q[0];
    tmr_d      = tmr_q;
    tmo_d      = tmo_q;
    if (sync2_q == 2'h3) begin
      tmr_d = '0;                                    // both high: restart
      tmo_d = 1'b0;
    end else if (!tmo_q) begin
      if (tmr_q >= smb_pkg::TMR_W'(TIMEOUT_CYC)) begin
        ev_d.timeout = 1'b1;                         // fire once per low interval
        tmo_d        = 1'b1;
      end else begin
        tmr_d = tmr_q + 1'b1;
      end
    end
  end

  assign o_ev = ev_q;

  // ============================================================
  // checks
  a_timer_restart: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    sync2_q == 2'h3 |=> tmr_q == '0 && !ev_q.timeout)
    else $error("timer not restarted with both lines high");
  a_timeout_low: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    ev_d.timeout |-> sync2_q != 2'h3 && tmr_q == smb_pkg::TMR_W'(TIMEOUT_CYC))
    else $error("timeout without full low interval");

endmodule

// File: smb_mst.sv
`timescale 1ns/1ps
// ============================================================
// bus master model, data line pulled low through an open drain
module smb_mst #(
  parameter int unsigned HALF = 8
) (
  // clock
  input  wire logic i_clk,
  // bus lines
  input  wire logic i_sda,
  output logic      o_scl,
  output logic      o_sda_pull
);
  // both lines released while idle
  initial begin
    o_scl = 1'b1;
    o_sda_pull = 1'b0;
  end

  // wait a number of falling edges
  task automatic pause(input int n);
    repeat (n) @(negedge i_clk);
  endtask

  // one bit: data moves mid-low, sampled late in high
  task automatic bit_io(input logic b, output logic s);
    pause(HALF);
    o_sda_pull = ~b;
    pause(HALF);
    o_scl = 1'b1;
    pause(HALF);
    s = i_sda;
    o_scl = 1'b0;
  endtask

  // start or repeated start, data falls with clock high
  task automatic start();
    pause(HALF);
    o_sda_pull = 1'b0;
    pause(HALF);
    o_scl = 1'b1;
    pause(HALF);
    o_sda_pull = 1'b1;
    pause(HALF);
    o_scl = 1'b0;
  endtask

  // stop, data rises with clock high, bus left free
  task automatic stop();
    pause(HALF);
    o_sda_pull = 1'b1;
    pause(HALF);
    o_scl = 1'b1;
    pause(HALF);
    o_sda_pull = 1'b0;
    pause(HALF);
  endtask

  // byte out msb first, clock held low for stall before ack bit
  task automatic wbyte(input logic [7:0] d, input int stall, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(d[i], s);
    pause(stall);
    bit_io(1'b1, ack);
  endtask

  // byte in msb first, then ack or nack
  task automatic rbyte(input logic nack, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, s);
      d[i] = s;
    end
    bit_io(nack, s);
  endtask
endmodule

// File: tb.sv
`timescale 1ns/1ps
// ============================================================
// self-checking bench for the serial slave interface
module tb;
  localparam int unsigned TMO = 400;
  localparam logic [6:0] DEV = 7'h47;

  logic       i_clk;
  logic       i_arst_n;
  logic       scl;
  logic       pull;
  logic       sda;
  logic       oe;
  logic       dout;
  logic [2:0] rd_addr;
  logic       wr_en;
  logic [2:0] wr_addr;
  logic [7:0] wr_data;
  logic [7:0] mem [8];
  int         n_mismatch;
  int         check_count;
  int         n_wr;

  // wired-and data line with pull-up, slave pulls to its drive level when enabled
  assign sda = ~(pull | (oe & ~dout));

  // clock
  always #12.5 i_clk = ~i_clk;

  // register file beside the slave, counts writes
  always @(posedge i_clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
      n_wr <= n_wr + 1;
    end
  end

  smb_slave #(.TIMEOUT_CYC(TMO)) u_smb_slave (
    .i_clk                       (i_clk),
    .i_arst_n                    (i_arst_n),
    .i_scl                       (scl),
    .i_sda_in                    (sda),
    .o_serial_data_output_pin    (dout),
    .o_serial_data_output_pin_oe (oe),
    .i_slave_addr                (DEV),
    .o_rd_addr                   (rd_addr),
    .i_rd_data                   (mem[rd_addr]),
    .o_wr_en                     (wr_en),
    .o_wr_addr                   (wr_addr),
    .o_wr_data                   (wr_data)
  );

  smb_mst u_smb_mst (
    .i_clk      (i_clk),
    .i_sda      (sda),
    .o_scl      (scl),
    .o_sda_pull (pull)
  );

  // compare and count
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // start, write address, command byte
  task automatic head(input logic [7:0] cmd, input int stall, output logic a1, output logic a2);
    u_smb_mst.start();
    u_smb_mst.wbyte({DEV, 1'b0}, stall, a1);
    u_smb_mst.wbyte(cmd, stall, a2);
  endtask

  // read byte, then read word wrapping to register 0
  task automatic t_read();
    logic a1, a2, a3;
    logic [7:0] d0, d1;
    head(8'hD2, 0, a1, a2);
    u_smb_mst.start();
    u_smb_mst.wbyte({DEV, 1'b1}, 0, a3);
    u_smb_mst.rbyte(1'b1, d0);
    u_smb_mst.stop();
    check("rd acks", {5'h00, a1, a2, a3}, 8'h00);
    check("read byte", d0, 8'h32);
    head(8'hD7, 0, a1, a2);
    u_smb_mst.start();
    u_smb_mst.wbyte({DEV, 1'b1}, 0, a3);
    u_smb_mst.rbyte(1'b0, d0);
    u_smb_mst.rbyte(1'b1, d1);
    u_smb_mst.stop();
    check("word first", d0, 8'h37);
    check("word second", d1, 8'h30);
    $display("test read done");
  endtask

  // write byte, then write word with dropped second byte
  task automatic t_write();
    logic a1, a2, a3, a4;
    int w0;
    w0 = n_wr;
    head(8'hD3, 0, a1, a2);
    u_smb_mst.wbyte(8'hA5, 0, a3);
    u_smb_mst.stop();
    check("wr acks", {5'h00, a1, a2, a3}, 8'h00);
    check("reg 3", mem[3], 8'hA5);
    check("idle oe", {7'h00, oe}, 8'h00);
    head(8'hD6, 0, a1, a2);
    u_smb_mst.wbyte(8'h5C, 0, a3);
    u_smb_mst.wbyte(8'h77, 0, a4);
    u_smb_mst.stop();
    check("word acks", {4'h0, a1, a2, a3, a4}, 8'h00);
    check("reg 6", mem[6], 8'h5C);
    check("reg 7", mem[7], 8'h37);
    check("writes", 8'(n_wr - w0), 8'h02);
    $display("test write done");
  endtask

  // unsupported commands and a foreign address
  task automatic t_refuse();
    logic [7:0] bad [4] = '{8'hE0, 8'hCF, 8'hD8, 8'h3F};
    logic a1, a2, a3;
    int w0;
    w0 = n_wr;
    foreach (bad[i]) begin
      head(bad[i], 0, a1, a2);
      u_smb_mst.wbyte(8'h5A, 0, a3);
      u_smb_mst.stop();
      check("bad cmd ack", {6'h00, a1, a2}, 8'h01);
      check("bad data ack", {7'h00, a3}, 8'h01);
    end
    u_smb_mst.start();
    u_smb_mst.wbyte({7'h12, 1'b0}, 0, a1);
    u_smb_mst.stop();
    check("addr nack", {7'h00, a1}, 8'h01);
    check("no write", 8'(n_wr - w0), 8'h00);
    $display("test refuse done");
  endtask

  // slow master, stuck clock, recovery
  task automatic t_timeout();
    logic a1, a2, a3;
    head(8'hD3, 250, a1, a2);
    u_smb_mst.wbyte(8'h69, 0, a3);
    u_smb_mst.stop();
    check("slow acks", {5'h00, a1, a2, a3}, 8'h00);
    check("slow reg 3", mem[3], 8'h69);
    u_smb_mst.start();
    u_smb_mst.wbyte({DEV, 1'b0}, 500, a1);
    check("stuck nack", {7'h00, a1}, 8'h01);
    check("released", {7'h00, oe}, 8'h00);
    u_smb_mst.stop();
    head(8'hD1, 0, a1, a2);
    u_smb_mst.wbyte(8'hC3, 0, a3);
    u_smb_mst.stop();
    check("recovered", mem[1], 8'hC3);
    $display("test timeout done");
  endtask

  // counts and verdict
  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // main sequence
  initial begin
    i_clk = 1'b0;
    i_arst_n = 1'b0;
    n_mismatch = 0;
    check_count = 0;
    n_wr = 0;
    for (int i = 0; i < 8; i++) mem[i] = 8'h30 + 8'(i);
    repeat (2) @(negedge i_clk);
    i_arst_n = 1'b1;
    repeat (4) @(negedge i_clk);
    check("reset oe", {7'h00, oe}, 8'h00);
    check("reset outs", {dout, wr_en, rd_addr, wr_addr}, 8'h00);
    check("reset data", wr_data, 8'h00);
    t_read();
    t_write();
    t_refuse();
    t_timeout();
    final_report();
  end

  // watchdog, several times the expected run
  initial begin
    #(60000 * 25);
    n_mismatch++;
    final_report();
  end
endmodule
